/* rtl/pmc_pkg.sv */
// pmc_pkg: register map, field layout and carriers for the power-mode controller
// assumes: one 25 MHz system clock, plain register port with one-cycle read latency
package pmc_pkg;
   localparam int unsigned pmc_addr_w = 2;
   localparam int unsigned pmc_data_w = 8;
   // register offsets
   localparam logic [1:0] pmc_off_mode = 2'h0;
   localparam logic [1:0] pmc_off_cfg = 2'h1;
   localparam logic [1:0] pmc_off_status = 2'h2;
   // power-mode register fields
   localparam int unsigned pmc_bit_idle = 0;
   localparam int unsigned pmc_bit_sleep = 1;
   localparam int unsigned pmc_flags_lsb = 2;
   localparam int unsigned pmc_flags_w = 6;
   // configuration register fields
   localparam int unsigned pmc_bit_cut = 0;
   localparam int unsigned pmc_bit_mcd_en = 1;
   // reset values
   localparam logic [5:0] pmc_flags_rst = 6'h00;
   localparam logic pmc_cut_rst = 1'b0;
   localparam logic pmc_mcd_en_rst = 1'b0;
   localparam logic [15:0] pmc_reset_vector = 16'h0000;
   // reset sequence length in system clocks
   localparam int unsigned pmc_reset_seq_cycles = 4;

   typedef enum logic [1:0] {
      pmc_run,
      pmc_idle,
      pmc_sleep,
      pmc_wake
   } pmc_mode_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pmc_bus_req_t;

   typedef struct packed {
      logic cpu_halt;
      logic osc_halt;
      logic periph_halt;
      logic regulator_off;
      logic core_reset;
      logic fetch_start;
      logic [15:0] fetch_addr;
   } pmc_ctrl_t;
endpackage

/* rtl/pmc_sync.sv */
// pmc_sync: three-stage synchroniser with agreement filter for async inputs
// assumes: input is a level from outside the system clock domain
`timescale 1ns/10ps
`default_nettype none
module pmc_sync #(
   parameter int unsigned width = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // data
   input wire logic [width-1:0] async_in,
   output logic [width-1:0] sync_out
);
   typedef struct packed {
      logic [width-1:0] s1;
      logic [width-1:0] s2;
      logic [width-1:0] s3;
      logic [width-1:0] out;
   } pmc_sync_state_t;

   pmc_sync_state_t st;
   pmc_sync_state_t next_st;

   initial begin
      if (width < 1) $error("pmc_sync width must be at least 1");
   end

   always_comb begin
      next_st = st;
      next_st.s1 = async_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // only s2 and s3 are looked at, s1 may be metastable
      for (int i = 0; i < width; i++) begin
         if (st.s2[i] == st.s3[i]) next_st.out[i] = st.s3[i];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) st <= '0;
      else st <= next_st;
   end

   assign sync_out = st.out;
endmodule // pmc_sync
`default_nettype wire

/* rtl/pmc_ctrl.sv */
// pmc_ctrl: power-mode controller, idle and deep-sleep entry, regulator cut, wake by reset
// assumes: core pulses insn_done at the end of each instruction; reset pins are async levels
`timescale 1ns/10ps
`default_nettype none
module pmc_ctrl #(
   parameter int unsigned reset_seq_cycles = pmc_pkg::pmc_reset_seq_cycles
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire pmc_pkg::pmc_bus_req_t bus,
   output logic [7:0] rdata,
   // core handshake
   input wire logic insn_done,
   input wire logic irq_pending,
   // reset sources, asynchronous levels, active high
   input wire logic reset_pin,
   input wire logic internal_reset_src,
   input wire logic mcd_timeout,
   // power and clock control
   output pmc_pkg::pmc_ctrl_t ctrl
);
   import pmc_pkg::*;

   initial begin
      if (reset_seq_cycles < 1 || reset_seq_cycles > 255)
         $error("pmc_ctrl reset_seq_cycles out of range");
   end

   typedef struct packed {
      pmc_mode_t mode;
      logic [5:0] flags;
      logic cut;
      logic mcd_en;
      logic sleep_req;
      logic [7:0] seq_cnt;
      logic [7:0] rdata;
      pmc_ctrl_t ctrl;
   } pmc_state_t;

   pmc_state_t st;
   pmc_state_t next_st;
   logic [2:0] rst_sync;
   logic pin_rst;
   logic int_rst;
   logic mcd_rst;
   logic wake_rst;

   pmc_sync #(
      .width(3)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({mcd_timeout, internal_reset_src, reset_pin}),
      .sync_out(rst_sync)
   );

   always_comb begin
      pin_rst = rst_sync[0];
      int_rst = rst_sync[1];
      // detector only resets when enabled
      mcd_rst = rst_sync[2] && st.mcd_en;
      // regulator cut leaves only the pin, internal sources are unpowered
      if (st.cut && st.mode == pmc_sleep) begin
         wake_rst = pin_rst;
      end else begin
         wake_rst = pin_rst || int_rst || mcd_rst;
      end
   end

   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;
      next_st.ctrl.fetch_start = 1'b0;
      if (bus.rd) begin
         case (bus.addr)
            // idle and sleep select bits never read back, the mode reads back at status
            pmc_off_mode: next_st.rdata = {st.flags, 2'b00};
            pmc_off_cfg: next_st.rdata = {6'h00, st.mcd_en, st.cut};
            pmc_off_status: next_st.rdata = {6'h00, 2'(st.mode)};
            default: next_st.rdata = 8'h00;
         endcase
      end
      if (bus.wr && st.mode == pmc_run) begin
         case (bus.addr)
            pmc_off_mode: begin
               next_st.flags = bus.wdata[pmc_flags_lsb +: pmc_flags_w];
               if (bus.wdata[pmc_bit_sleep]) begin
                  next_st.sleep_req = 1'b1;
               end else if (bus.wdata[pmc_bit_idle]) begin
                  next_st.mode = pmc_idle;
               end
            end
            pmc_off_cfg: begin
               next_st.cut = bus.wdata[pmc_bit_cut];
               next_st.mcd_en = bus.wdata[pmc_bit_mcd_en];
            end
            default: ;
         endcase
      end
      case (st.mode)
         pmc_run: begin
            // wait for the writing instruction to retire before stopping
            if (st.sleep_req && insn_done) begin
               next_st.sleep_req = 1'b0;
               next_st.mode = pmc_sleep;
            end
         end
         pmc_idle: begin
            if (irq_pending) next_st.mode = pmc_run;
         end
         pmc_sleep: ; // no interrupt or write leaves here
         pmc_wake: begin
            if (st.seq_cnt == 8'h00) begin
               next_st.mode = pmc_run;
               next_st.ctrl.fetch_start = 1'b1;
            end else begin
               next_st.seq_cnt = st.seq_cnt - 8'h01;
            end
         end
         default: next_st.mode = pmc_run;
      endcase
      if (wake_rst) begin
         // any reset aborts idle or sleep and restarts the sequence
         next_st.mode = pmc_wake;
         next_st.sleep_req = 1'b0;
         next_st.flags = pmc_flags_rst;
         next_st.cut = pmc_cut_rst;
         next_st.mcd_en = pmc_mcd_en_rst;
         next_st.seq_cnt = 8'(reset_seq_cycles - 1);
         next_st.ctrl.fetch_start = 1'b0;
      end
      next_st.ctrl.cpu_halt = next_st.mode != pmc_run;
      // peripherals keep running in idle
      next_st.ctrl.osc_halt = next_st.mode == pmc_sleep;
      next_st.ctrl.periph_halt = next_st.mode == pmc_sleep;
      next_st.ctrl.regulator_off = next_st.mode == pmc_sleep && next_st.cut;
      next_st.ctrl.core_reset = next_st.mode == pmc_wake;
      next_st.ctrl.fetch_addr = pmc_reset_vector;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
         st.mode <= pmc_run;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign ctrl = st.ctrl;
endmodule // pmc_ctrl
`default_nettype wire

/* tb/pmc_ctrl_sva.sv */
// pmc_ctrl_sva: port-level checks of the power-mode controller
// assumes: bound onto pmc_ctrl, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module pmc_ctrl_sva #(
   parameter int unsigned reset_seq_cycles = pmc_pkg::pmc_reset_seq_cycles
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire pmc_pkg::pmc_bus_req_t bus,
   input wire logic [7:0] rdata,
   // core and reset sources
   input wire logic insn_done,
   input wire logic irq_pending,
   input wire logic reset_pin,
   input wire logic internal_reset_src,
   input wire logic mcd_timeout,
   // control outputs
   input wire pmc_pkg::pmc_ctrl_t ctrl
);
   import pmc_pkg::*;
   logic [7:0] held;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // length of the reset sequence, zero outside it
   always_ff @(posedge clock) held <= ctrl.core_reset ? held + 8'h01 : 8'h00;
   sequence s_mode_wr(logic [1:0] d);
      bus.wr && bus.addr == pmc_off_mode && bus.wdata[1:0] == d && !ctrl.cpu_halt
         && !ctrl.core_reset;
   endsequence
   property p_rd; bus.rd && bus.addr == pmc_off_mode |=> rdata[1:0] == 2'h0; endproperty
   a_rd: assert property (p_rd) else $error("select bits read nonzero");
   property p_idle; s_mode_wr(2'h1) |=> ctrl.cpu_halt && !ctrl.periph_halt && !ctrl.osc_halt;
   endproperty
   a_idle: assert property (p_idle) else $error("idle entry wrong");
   // wake also halts only the cpu, so the reset sequence is left out here
   property p_irq; ctrl.cpu_halt && !ctrl.periph_halt && !ctrl.core_reset && irq_pending
      |=> !ctrl.cpu_halt;
   endproperty
   a_irq: assert property (p_irq) else $error("idle kept after interrupt");
   property p_sleep; s_mode_wr(2'h2) ##1 insn_done
      |-> ##[1:2] ctrl.periph_halt && ctrl.cpu_halt && ctrl.osc_halt; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
   // sleep hands over straight to the reset sequence in the same cycle
   property p_wake; $fell(ctrl.periph_halt) |-> ctrl.core_reset; endproperty
   a_wake: assert property (p_wake) else $error("sleep left without reset");
   // a long reset source stretches the sequence, so only the minimum is fixed
   property p_seq; $fell(ctrl.core_reset)
      |-> held >= reset_seq_cycles - 1 && ctrl.fetch_start; endproperty
   a_seq: assert property (p_seq) else $error("reset sequence wrong");
   property p_reg; ctrl.regulator_off |-> ctrl.periph_halt; endproperty
   a_reg: assert property (p_reg) else $error("regulator off outside sleep");
   property p_cut; (ctrl.regulator_off && !reset_pin) [*6] |=> !ctrl.core_reset; endproperty
   a_cut: assert property (p_cut) else $error("reset taken with regulator cut");
endmodule // pmc_ctrl_sva
bind pmc_ctrl pmc_ctrl_sva #(.reset_seq_cycles(reset_seq_cycles)) chk (.clock(clock),
   .rst_n(rst_n), .bus(bus), .rdata(rdata), .insn_done(insn_done), .irq_pending(irq_pending),
   .reset_pin(reset_pin), .internal_reset_src(internal_reset_src), .mcd_timeout(mcd_timeout),
   .ctrl(ctrl));
`default_nettype wire

/* tb/testbench.sv */
// testbench: self-checking run of the power-mode controller
// assumes: pmc_ctrl with its checker bound, 25 MHz clock
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pmc_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   pmc_bus_req_t bus = '0;
   logic [7:0] rdata;
   logic insn_done = 1'b0;
   logic irq_pending = 1'b0;
   logic [2:0] src = 3'h0; // pin, internal, missing clock
   pmc_ctrl_t ctrl;
   int fails = 0;
   int checked = 0;
   logic [7:0] lfsr = 8'h0e;
   always #20 clock = ~clock;
   pmc_ctrl uut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .insn_done(insn_done),
      .irq_pending(irq_pending), .reset_pin(src[2]), .internal_reset_src(src[1]),
      .mcd_timeout(src[0]), .ctrl(ctrl));
   function automatic logic [7:0] step(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e, input string n);
      @(posedge clock);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 check(n, rdata, e);
   endtask
   // short pulse: a held level would keep the core in reset
   task automatic kick(input logic [2:0] s, output logic w);
      @(posedge clock);
      src <= s;
      repeat (6) @(posedge clock);
      src <= 3'h0;
      w = 1'b0;
      for (int i = 0; i < 30 && !w; i++) begin
         @(posedge clock);
         #1 w = (ctrl.fetch_start === 1'b1);
      end
   endtask
   task automatic nap(input logic [7:0] cfg, input logic [2:0] s1, input logic [2:0] s2);
      logic w;
      wr(pmc_off_cfg, cfg);
      // clock source and analog shutdown are settled by software beforehand
      wr(pmc_off_mode, 8'h02);
      insn_done <= 1'b1;
      @(posedge clock);
      insn_done <= 1'b0;
      repeat (2) @(posedge clock);
      #1 check("halts", {ctrl.cpu_halt, ctrl.osc_halt, ctrl.periph_halt}, 3'h7);
      check("regulator off", ctrl.regulator_off, cfg[0]);
      kick(s1, w);
      check("woken", w, s2 == 3'h0);
      if (s2 != 3'h0)
         kick(s2, w);
      if (w !== 1'b1) begin
         fails++;
         test_done();
      end
      check("fetch address", ctrl.fetch_addr, 16'h0000);
      rd(pmc_off_mode, 8'h00, "flags after wake");
      check("running", {ctrl.cpu_halt, ctrl.periph_halt}, 2'h0);
      $display("sleep test done");
   endtask
   initial begin
      logic [7:0] d;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      rd(pmc_off_mode, 8'h00, "mode reset");
      rd(2'h3, 8'h00, "unmapped");
      for (int k = 0; k < 8; k++) begin
         lfsr = step(lfsr);
         d = (k == 0) ? 8'hfc : lfsr & 8'hfc;
         wr(pmc_off_mode, d);
         rd(pmc_off_mode, d, "flags");
      end
      $display("flags test done");
      wr(pmc_off_mode, 8'ha5);
      #1 check("idle halts", {ctrl.cpu_halt, ctrl.osc_halt, ctrl.periph_halt}, 3'h4);
      rd(pmc_off_mode, 8'ha4, "select reads");
      @(posedge clock);
      irq_pending <= 1'b1;
      @(posedge clock);
      irq_pending <= 1'b0;
      #1 check("idle left", ctrl.cpu_halt, 1'b0);
      $display("idle test done");
      nap(8'h00, 3'h1, 3'h2);
      nap(8'h02, 3'h1, 3'h0);
      nap(8'h01, 3'h2, 3'h4);
      test_done();
   end
endmodule // testbench
`default_nettype wire
